// [rtl/mmsr_pkg.sv]
// package of constants shared by the memory-mapped slave ram
package mmsr_pkg;

   // default geometry
   localparam int DATA_W_DEF     = 32;
   localparam int ADDR_W_DEF     = 16;
   localparam int WAIT_WR_DEF    = 2;
   localparam int RD_LAT_DEF     = 2;
   localparam int SIZE_DEF       = 1024;
   localparam int OFFSET_DEF     = 1;

   // legal parameter ranges
   localparam int ADDR_W_MIN     = 1;
   localparam int ADDR_W_MAX     = 32;
   localparam int WAIT_WR_MAX    = 10;
   localparam int RD_LAT_MIN     = 1;
   localparam int RD_LAT_MAX     = 255;

   // reset value of every control flop
   localparam logic RST_LOW      = 1'b0;

   // write sequencer states
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_WAIT,
      WR_DONE
   } mmsr_wr_state_t;

   // legal data widths only
   function automatic bit mmsr_width_ok(input int w);
      return (w == 8) || (w == 16) || (w == 32) || (w == 64) || (w == 128);
   endfunction

endpackage

// [rtl/mmsr_rd_pipe.sv]
// read-return delay line: data and valid shifted by a fixed latency
`timescale 1ns/1ps
module mmsr_rd_pipe #(
   parameter int DATA_W = mmsr_pkg::DATA_W_DEF,
   parameter int LAT    = mmsr_pkg::RD_LAT_DEF
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // stage zero
   input  wire logic              inValid,
   input  wire logic [DATA_W-1:0] inWord,
   // last stage
   output logic                   outValid,
   output logic [DATA_W-1:0]      outWord
);

   logic [LAT-1:0]   validPipe_reg;
   logic [DATA_W-1:0] wordPipe_reg [LAT];

   // valid chain is reset so no stray strobe leaves after reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         validPipe_reg <= '0;
      end else begin
         validPipe_reg[0] <= inValid;
         for (int i = 1; i < LAT; i++) begin
            validPipe_reg[i] <= validPipe_reg[i-1];
         end
      end
   end

   // data chain is not reset; only meaningful alongside valid
   always_ff @(posedge core_clk) begin
      wordPipe_reg[0] <= inWord;
      for (int i = 1; i < LAT; i++) begin
         wordPipe_reg[i] <= wordPipe_reg[i-1];
      end
   end

   assign outValid = validPipe_reg[LAT-1];
   assign outWord  = wordPipe_reg[LAT-1];

endmodule

// [rtl/mmsr_ram.sv]
// memory-mapped slave ram with write wait states and pipelined reads
//
// Summary of operation
// - the block stores words over an address range and returns written data on reads as a bus slave.
// - the data width may only be 8, 16, 32, 64 or 128 bits and any other value is refused at elaboration.
// - the address width is a parameter from 1 to 32 bits shared by the write and read address inputs.
// - each write costs a fixed number of wait states from 0 to 10 during which the write stall is held.
// - reads are pipelined and the data returns a fixed latency of 1 to 255 cycles after acceptance.
// - the read-valid strobe is high exactly in the cycle the read data output carries returned data.
// - the write stall is high whenever a pending write cannot be taken at once.
// - the read stall is high whenever a pending read cannot be taken at once.
// - the capacity is a parameter in words equal to the number of addresses in the range.
// - an offset parameter sets the first address and offset plus size must stay below two to the address width.
`timescale 1ns/1ps
module mmsr_ram #(
   parameter int DATA_W  = mmsr_pkg::DATA_W_DEF,
   parameter int ADDR_W  = mmsr_pkg::ADDR_W_DEF,
   parameter int WAIT_WR = mmsr_pkg::WAIT_WR_DEF,
   parameter int RD_LAT  = mmsr_pkg::RD_LAT_DEF,
   parameter int SIZE    = mmsr_pkg::SIZE_DEF,
   parameter int OFFSET  = mmsr_pkg::OFFSET_DEF
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // write port
   input  wire logic              wrReq,
   input  wire logic [ADDR_W-1:0] wr_addr_in,
   input  wire logic [DATA_W-1:0] wr_word_in,
   output logic                   wr_stall,
   // read port
   input  wire logic              rdReq,
   input  wire logic [ADDR_W-1:0] rd_addr_in,
   output logic                   rd_stall,
   output logic [DATA_W-1:0]      rd_word_out,
   output logic                   rd_word_valid
);

   ////////////////////////////////////////////////////////////////////////////
   // parameter checks

   localparam longint RANGE_END = longint'(OFFSET) + longint'(SIZE);
   localparam longint ADDR_SPAN = longint'(1) << ADDR_W;

   // bad settings stop elaboration rather than build a wrong memory;
   // each check except the range check names the offending value so the user can fix the instance
   generate
      // only the five listed word widths are legal
      if (!mmsr_pkg::mmsr_width_ok(DATA_W)) begin : g_bad_width
         $error("mmsr_ram: unsupported data width %0d", DATA_W);
      end
      // address width shared by both ports
      if (ADDR_W < mmsr_pkg::ADDR_W_MIN || ADDR_W > mmsr_pkg::ADDR_W_MAX) begin : g_bad_addr
         $error("mmsr_ram: unsupported address width %0d", ADDR_W);
      end
      // the wait-state counter is four bits wide, so the cap also guards it
      if (WAIT_WR < 0 || WAIT_WR > mmsr_pkg::WAIT_WR_MAX) begin : g_bad_wait
         $error("mmsr_ram: unsupported write wait states %0d", WAIT_WR);
      end
      // a zero latency would leave the delay line without stages
      if (RD_LAT < mmsr_pkg::RD_LAT_MIN || RD_LAT > mmsr_pkg::RD_LAT_MAX) begin : g_bad_lat
         $error("mmsr_ram: unsupported read latency %0d", RD_LAT);
      end
      // the range must fit below the top of the address space
      if (SIZE < 1 || RANGE_END >= ADDR_SPAN) begin : g_bad_range
         $error("mmsr_ram: address range does not fit the address width");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // storage and address decode

   // one word per address; size counts addresses
   logic [DATA_W-1:0] memArray [SIZE];

   localparam int IDX_W = (SIZE > 1) ? $clog2(SIZE) : 1;

   // in-range test, used by both ports
   function automatic bit inRange(input logic [ADDR_W-1:0] a);
      return (longint'(a) >= longint'(OFFSET)) && (longint'(a) < RANGE_END);
   endfunction

   // word index relative to the start of the range
   function automatic logic [IDX_W-1:0] toIndex(input logic [ADDR_W-1:0] a);
      longint d;
      d = longint'(a) - longint'(OFFSET);
      return d[IDX_W-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // write sequencer

   localparam int WCNT_W = 4;
   localparam logic [WCNT_W-1:0] WAIT_CNT = WCNT_W'(WAIT_WR);

   mmsr_pkg::mmsr_wr_state_t wrState_reg;
   mmsr_pkg::mmsr_wr_state_t wrState_next;
   logic [WCNT_W-1:0]        wrCnt_reg;
   logic                     wrStall_reg;
   logic                     wrCommit;

   // a write is committed on the edge where request is high and stall low
   assign wrCommit = wrReq && !wrStall_reg;

   // stall is raised at a new request and held for the wait states;
   // with zero wait states it never rises
   always_comb begin
      wrState_next = wrState_reg;
      case (wrState_reg)
         mmsr_pkg::WR_IDLE: begin
            if (wrReq && WAIT_WR != 0) begin
               wrState_next = mmsr_pkg::WR_WAIT;
            end
         end
         mmsr_pkg::WR_WAIT: begin
            if (wrCnt_reg == WCNT_W'(1)) begin
               wrState_next = mmsr_pkg::WR_DONE;
            end
         end
         mmsr_pkg::WR_DONE: begin
            wrState_next = mmsr_pkg::WR_IDLE;  // write commits in this cycle
         end
         default: begin
            wrState_next = mmsr_pkg::WR_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrState_reg <= mmsr_pkg::WR_IDLE;
      end else begin
         wrState_reg <= wrState_next;
      end
   end

   // wait-state counter loaded on entry to the wait phase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrCnt_reg <= '0;
      end else if (wrState_reg == mmsr_pkg::WR_IDLE && wrState_next == mmsr_pkg::WR_WAIT) begin
         wrCnt_reg <= WAIT_CNT;
      end else if (wrState_reg == mmsr_pkg::WR_WAIT) begin
         wrCnt_reg <= wrCnt_reg - WCNT_W'(1);
      end
   end

   // registered stall output: high for exactly the wait states
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrStall_reg <= mmsr_pkg::RST_LOW;
      end else begin
         wrStall_reg <= (wrState_next == mmsr_pkg::WR_WAIT);
      end
   end

   assign wr_stall = wrStall_reg;

   // store committed in-range words; others are dropped silently
   always_ff @(posedge core_clk) begin
      if (wrCommit && inRange(wr_addr_in)) begin
         memArray[toIndex(wr_addr_in)] <= wr_word_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   // the pipeline accepts one read per cycle, so reads never stall;
   // the output is still a flop so the contract can change later
   logic rdStall_reg;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdStall_reg <= mmsr_pkg::RST_LOW;
      end else begin
         rdStall_reg <= mmsr_pkg::RST_LOW;
      end
   end

   assign rd_stall = rdStall_reg;

   logic              rdTake;
   logic [DATA_W-1:0] rdWord;

   assign rdTake = rdReq && !rdStall_reg;

   // out-of-range reads return zero: still strobed, but carry no content
   always_comb begin
      rdWord = '0;
      if (inRange(rd_addr_in)) begin
         rdWord = memArray[toIndex(rd_addr_in)];
      end
   end

   // latency counted from the accepting edge to the valid cycle
   mmsr_rd_pipe #(
      .DATA_W (DATA_W),
      .LAT    (RD_LAT)
   ) u_rd_pipe (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .inValid  (rdTake),
      .inWord   (rdWord),
      .outValid (rd_word_valid),
      .outWord  (rd_word_out)
   );

endmodule

// [bench/mmsr_ram_chk.sv]
// port checker for the slave ram
`timescale 1ns/1ps
module mmsr_ram_chk #(
   parameter int ADDR_W  = 16,
   parameter int DATA_W  = 32,
   parameter int WAIT_WR = 2,
   parameter int RD_LAT  = 2,
   parameter int SIZE    = 1024,
   parameter int OFFSET  = 1
) (
   // clock and reset
   input wire logic              core_clk,
   input wire logic              rst_b,
   // watched ports
   input wire logic              wrReq,
   input wire logic              wr_stall,
   input wire logic              rdReq,
   input wire logic [ADDR_W-1:0] rd_addr_in,
   input wire logic              rd_stall,
   input wire logic [DATA_W-1:0] rd_word_out,
   input wire logic              rd_word_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////
   // length of the running stall; the wait count may reach 10, more than a repetition may unroll
   logic [4:0] stallRun_reg;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stallRun_reg <= '0;
      end else if (wr_stall) begin
         stallRun_reg <= stallRun_reg + 5'h01;
      end else begin
         stallRun_reg <= '0;
      end
   end
   // a fresh write request meets an idle port
   sequence s_wr_new; $rose(wrReq) && !wr_stall; endsequence
   // stall falls after exactly the configured wait states
   sequence s_wr_end; $fell(wr_stall) ##0 stallRun_reg == 5'(WAIT_WR); endsequence
   property p_wr_hold; $fell(wr_stall) |-> s_wr_end; endproperty
   property p_wr_cap; wr_stall |-> stallRun_reg < 5'(WAIT_WR); endproperty
   property p_wr_start; s_wr_new |=> (wr_stall == (WAIT_WR != 0)); endproperty
   property p_stall_cause; $rose(wr_stall) |-> $past(wrReq); endproperty
   property p_idle_free; !wrReq && !wr_stall |=> !wr_stall; endproperty
   property p_rd_lat; rdReq && !rd_stall |-> ##RD_LAT rd_word_valid; endproperty
   property p_valid_cause; rd_word_valid |-> $past(rdReq, RD_LAT); endproperty
   property p_rd_free; !rd_stall; endproperty
   property p_oor; rdReq && (rd_addr_in < OFFSET || rd_addr_in >= OFFSET + SIZE) |-> ##RD_LAT rd_word_out == '0;
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write stall length wrong");
   a_wr_cap: assert property (p_wr_cap) else $error("write stall too long");
   a_wr_start: assert property (p_wr_start) else $error("write stall missing");
   a_stall_cause: assert property (p_stall_cause) else $error("stall without write");
   a_idle_free: assert property (p_idle_free) else $error("idle stall");
   a_rd_lat: assert property (p_rd_lat) else $error("read data late");
   a_valid_cause: assert property (p_valid_cause) else $error("stray read valid");
   a_rd_free: assert property (p_rd_free) else $error("read stalled");
   a_oor: assert property (p_oor) else $error("outside read not zero");
endmodule
bind mmsr_ram mmsr_ram_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .WAIT_WR(WAIT_WR), .RD_LAT(RD_LAT), .SIZE(SIZE),
   .OFFSET(OFFSET)) u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .wrReq(wrReq), .wr_stall(wr_stall), .rdReq(rdReq), .rd_addr_in(rd_addr_in),
   .rd_stall(rd_stall), .rd_word_out(rd_word_out), .rd_word_valid(rd_word_valid));

// [bench/mmsr_master.sv]
// bus master model issuing writes and reads
`timescale 1ns/1ps
module mmsr_master #(
   parameter int AW = 6,
   parameter int DW = 8
) (
   // clock
   input wire logic     core_clk,
   // write side
   output logic          wrReq,
   output logic [AW-1:0] wr_addr_in,
   output logic [DW-1:0] wr_word_in,
   input wire logic      wr_stall,
   // read side
   output logic          rdReq,
   output logic [AW-1:0] rd_addr_in,
   input wire logic      rd_stall
);
   // idle lines at time zero
   initial begin
      wrReq = 1'b0; rdReq = 1'b0; wr_addr_in = '0; wr_word_in = '0; rd_addr_in = '0;
   end
   // hold request, address and data until taken after the stall; released lines go inverted
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      bit seen;
      seen = 0;
      do @(posedge core_clk); while (wr_stall);
      wrReq <= 1'b1; wr_addr_in <= a; wr_word_in <= d;
      do begin
         @(posedge core_clk);
         if (wr_stall) seen = 1;
      end while (!(seen && !wr_stall));
      wrReq <= 1'b0; wr_addr_in <= ~a; wr_word_in <= ~d;
   endtask
   // n reads back to back from address a upward
   task automatic rd(input logic [AW-1:0] a, input int n);
      @(posedge core_clk);
      rdReq <= 1'b1;
      for (int i = 0; i < n; i++) begin
         rd_addr_in <= AW'(a + i);
         do @(posedge core_clk); while (rd_stall);
      end
      rdReq <= 1'b0; rd_addr_in <= ~AW'(a + n - 1);
   endtask
endmodule

// [bench/tb_mmsr_ram.sv]
// self-checking bench for the slave ram
`timescale 1ns/1ps
module tb_mmsr_ram;
   localparam int DW = 8, AW = 6, L = 2, SZ = 16, OF = 4;
   logic core_clk, rst_b, wrReq, wr_stall, rdReq, rd_stall, rd_word_valid;
   logic [AW-1:0] wr_addr_in, rd_addr_in;
   logic [DW-1:0] wr_word_in, rd_word_out, mem [64], qDat[$];
   int qDue[$], cyc, fail_count, tests_run;
   logic [31:0] seed = 32'hc016;
   mmsr_ram #(.DATA_W(DW), .ADDR_W(AW), .WAIT_WR(2), .RD_LAT(L), .SIZE(SZ), .OFFSET(OF)) u_dut (
      .core_clk(core_clk), .rst_b(rst_b), .wrReq(wrReq), .wr_addr_in(wr_addr_in), .wr_word_in(wr_word_in),
      .wr_stall(wr_stall), .rdReq(rdReq), .rd_addr_in(rd_addr_in), .rd_stall(rd_stall),
      .rd_word_out(rd_word_out), .rd_word_valid(rd_word_valid));
   mmsr_master #(.AW(AW), .DW(DW)) u_mst (
      .core_clk(core_clk), .wrReq(wrReq), .wr_addr_in(wr_addr_in), .wr_word_in(wr_word_in),
      .wr_stall(wr_stall), .rdReq(rdReq), .rd_addr_in(rd_addr_in), .rd_stall(rd_stall));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction
   function automatic bit inr(logic [AW-1:0] a);
      return a >= OF && a < OF + SZ;
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (e !== g) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      if (fail_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // 100 MHz clock and cycle watchdog
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (8000) @(posedge core_clk);
      fail_count++;
      summarize();
   end
   // reference model: reads see contents before a same-edge write
   always @(posedge core_clk) begin
      if (!rst_b) begin
         qDue.delete(); qDat.delete();
      end else begin
         cyc++;
         if (qDue.size() > 0 && qDue[0] == cyc) begin
            chk("rd_word_valid", 1, rd_word_valid);
            chk("rd_word_out", qDat[0], rd_word_out);
            void'(qDue.pop_front()); void'(qDat.pop_front());
         end else chk("rd_word_valid", 0, rd_word_valid);
         chk("rd_stall", 0, rd_stall);
         if (rdReq) begin
            qDue.push_back(cyc + L);
            qDat.push_back(inr(rd_addr_in) ? mem[rd_addr_in] : '0);
         end
         if (wrReq && !wr_stall && inr(wr_addr_in)) mem[wr_addr_in] = wr_word_in;
      end
   end
   ////////////////////////////////////////////////////////////////
   // main sequence: fill, sweep past both range ends, random traffic, overlap, reset
   initial begin
      rst_b = 1'b0;
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int a = OF; a < OF + SZ; a++) u_mst.wr(AW'(a), DW'(rnd()));
      u_mst.rd(AW'(OF - 1), SZ + 2);
      repeat (20) begin
         u_mst.wr(AW'(rnd()), DW'(rnd()));
         u_mst.rd(AW'(rnd()), 3);
      end
      fork
         u_mst.wr(AW'(OF + 3), DW'(rnd()));
         u_mst.rd(AW'(OF + 1), 6);
      join
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      u_mst.rd(AW'(OF), SZ);
      repeat (L + 4) @(posedge core_clk);
      summarize();
   end
endmodule
